//--- hw/pplp_ctrl.sv
// port receive control, repeating and automatic low-power sequencing
`timescale 1ns/1ps
`include "pplp_defines.svh"
// Function
// - a port that is receiving has both its drivers off and its receivers on.
// - incoming data-strobe is decoded to bits and retimed onto the local clock for the link layer.
// - a received packet is repeated on every other connected and active port.
// - line comparators give arbitration status and first-pair common mode picks the next speed.
// - bias seen on the second pair of a port marks that port as connected.
// - in host state D2 or D3 with all ports inactive and the link power-status bit clear the block drops into low-power mode by itself.
// - in low-power mode clock generators stop and only the needed detectors stay on per port.
// - deepest sleep only when every port is disconnected, or disabled with its interrupt enable clear.
// - software setting the link power-status bit, bit 19 of the set/clear pair, wakes the block.
// - bias or disconnect on a suspended port, or a new connection on an enabled port, wakes it.
// - after the link power-status bit is set in low power, clocks run again within 2 ms.
// - a physical-layer register access while the clock is stopped fails with an error pulse.
// - the link layer and the physical layer share the system clock for bit transfer.
module pplp_ctrl import pplp_pkg::*; #(
    parameter int NP = 2,
    parameter int WAKE_CYC = `PPLP_WAKE_CYC,
    parameter int BUF_DEPTH = 2
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // register access
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_ack_out,
    // physical-layer register access
    input wire logic phy_req_in,
    output logic phy_ack_out,
    output logic phy_access_fail_out,
    // host and port state
    input wire logic [1:0] host_pwr_state_in,
    input wire logic [NP-1:0] port_disabled_in,
    input wire logic [NP-1:0] port_suspended_in,
    input wire logic [NP-1:0] port_int_en_in,
    // cable pins
    input wire logic [NP-1:0] cable_pair_first_in,
    input wire logic [NP-1:0] cable_pair_second_in,
    input wire logic [NP-1:0] bias_sense_in,
    input wire logic [NP-1:0][1:0] cmp_in,
    input wire logic [NP-1:0][1:0] cm_speed_in,
    output logic [NP-1:0] cable_pair_first_out,
    output logic [NP-1:0] cable_pair_first_oe_out,
    output logic [NP-1:0] cable_pair_second_out,
    output logic [NP-1:0] cable_pair_second_oe_out,
    output logic [NP-1:0] rx_en_out,
    output logic [NP-1:0] detect_en_out,
    // arbitration
    output logic [NP-1:0][1:0] arb_status_out,
    output logic [1:0] next_speed_out,
    output logic [NP-1:0] port_connected_out,
    // link-layer receive stream
    output logic [7:0] llc_rx_data_out,
    output logic llc_rx_valid_out,
    input wire logic llc_rx_ready_in,
    output logic rx_overrun_out,
    // power
    output logic clk_gen_en_out,
    output logic sysclk_gate_en_out,
    output logic low_power_out,
    output logic deep_sleep_out
);
    localparam int WCW = $clog2(WAKE_CYC + 1);
    localparam int SLW = $clog2(NP) > 0 ? $clog2(NP) : 1;

    logic [NP-1:0] rx_act, bit_stb, bit_val, data_lvl, strobe_lvl, conn;
    logic [NP-1:0][1:0] cmp, speed;

    // ************************************************
    // port receivers
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_port
            pplp_port_if pif();
            pplp_port_rx u_rx (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .pair_first_in(cable_pair_first_in[g]),
                .pair_second_in(cable_pair_second_in[g]),
                .bias_sense_in(bias_sense_in[g]),
                .cmp_in(cmp_in[g]),
                .cm_speed_in(cm_speed_in[g]),
                .port(pif.rx)
            );
            assign rx_act[g] = pif.rx_active;
            assign bit_stb[g] = pif.bit_stb;
            assign bit_val[g] = pif.bit_val;
            assign data_lvl[g] = pif.data_lvl;
            assign strobe_lvl[g] = pif.strobe_lvl;
            // remote bias marks the port connected
            assign conn[g] = pif.bias;
            assign cmp[g] = pif.cmp;
            assign speed[g] = pif.speed;
        end
    endgenerate

    // ************************************************
    // register file
    // ************************************************
    logic [31:0] hcc_r, hcc_nxt, rdata_r, rdata_nxt;
    logic ack_r, ack_nxt, lps_set;

    always_comb begin
        hcc_nxt = hcc_r;
        rdata_nxt = rdata_r;
        ack_nxt = reg_wr_in | reg_rd_in;
        lps_set = reg_wr_in && reg_addr_in == `PPLP_HCC_SET_OFS && reg_wdata_in[`PPLP_HCC_LPS_BIT];
        if (reg_wr_in && reg_addr_in == `PPLP_HCC_SET_OFS) begin
            hcc_nxt = hcc_r | reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == `PPLP_HCC_CLR_OFS) begin
            hcc_nxt = hcc_r & ~reg_wdata_in;
        end
        if (reg_rd_in) begin
            if (reg_addr_in == `PPLP_HCC_SET_OFS || reg_addr_in == `PPLP_HCC_CLR_OFS) begin
                rdata_nxt = hcc_r;
            end else begin
                rdata_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hcc_r <= `PPLP_HCC_RESET;
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else begin
            hcc_r <= hcc_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    // ************************************************
    // low-power sequencer
    // ************************************************
    pplp_lp_e st_r, st_nxt;
    logic [WCW-1:0] wcnt_r, wcnt_nxt;
    logic [NP-1:0] conn_prev_r, conn_prev_nxt;
    logic [NP-1:0] rise, fall, inactive, deep_port;
    logic all_inactive, deep_ok, port_evt, host_low;
    logic phy_ack_r, phy_ack_nxt, phy_fail_r, phy_fail_nxt;

    always_comb begin
        conn_prev_nxt = conn;
        rise = conn & ~conn_prev_r;
        fall = ~conn & conn_prev_r;
        inactive = ~conn | port_disabled_in | port_suspended_in;
        all_inactive = &inactive;
        // ports that allow the deepest state
        deep_port = ~conn | (port_disabled_in & ~port_int_en_in);
        deep_ok = &deep_port;
        // events that must be answered or reported
        port_evt = |(port_suspended_in & (rise | fall)) | |(rise & ~port_disabled_in);
        host_low = host_pwr_state_in >= `PPLP_PWR_D2;
        st_nxt = st_r;
        wcnt_nxt = wcnt_r;
        unique case (st_r)
            st_active: begin
                // automatic entry, held off while software keeps the link powered
                if (host_low && all_inactive && !hcc_r[`PPLP_HCC_LPS_BIT] && !port_evt) begin
                    st_nxt = deep_ok ? st_deep : st_sleep;
                end
            end
            st_sleep, st_deep: begin
                if (lps_set || port_evt) begin
                    st_nxt = st_wake;
                    wcnt_nxt = '0;
                end else begin
                    st_nxt = deep_ok ? st_deep : st_sleep;
                end
            end
            st_wake: begin
                // fixed settle, never beyond the limit
                if (wcnt_r >= WCW'(WAKE_CYC - 1)) begin
                    st_nxt = st_active;
                end else begin
                    wcnt_nxt = wcnt_r + 1'b1;
                end
            end
        endcase
        // no access while the clock is stopped
        phy_ack_nxt = phy_req_in && st_r == st_active;
        phy_fail_nxt = phy_req_in && st_r != st_active;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= st_active;
            wcnt_r <= '0;
            conn_prev_r <= '0;
            phy_ack_r <= 1'b0;
            phy_fail_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            wcnt_r <= wcnt_nxt;
            conn_prev_r <= conn_prev_nxt;
            phy_ack_r <= phy_ack_nxt;
            phy_fail_r <= phy_fail_nxt;
        end
    end

    // ************************************************
    // receive path and repeating
    // ************************************************
    logic [SLW-1:0] sel_r, sel_nxt;
    logic [2:0] bcnt_r, bcnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [1:0] spd_r, spd_nxt;
    logic byte_done, buf_ready, ovr_r, ovr_nxt, awake;
    logic [7:0] byte_data;
    logic [NP-1:0] fo_r, fo_nxt, foe_r, foe_nxt, so_r, so_nxt, soe_r, soe_nxt;
    logic [NP-1:0] rxe_r, rxe_nxt, det_r, det_nxt;

    always_comb begin
        awake = st_r == st_active;
        sel_nxt = sel_r;
        spd_nxt = spd_r;
        // hold the chosen port for the whole packet
        if (!rx_act[sel_r]) begin
            for (int p = NP - 1; p >= 0; p--) begin
                if (rx_act[p]) begin
                    sel_nxt = SLW'(p);
                end
            end
            // speed from first-pair common mode of a connected port
            for (int p = NP - 1; p >= 0; p--) begin
                if (conn[p]) begin
                    spd_nxt = speed[p];
                end
            end
        end
        // bits assembled msb first, partial byte dropped at packet end
        bcnt_nxt = bcnt_r;
        sh_nxt = sh_r;
        byte_done = 1'b0;
        byte_data = {sh_r[6:0], bit_val[sel_r]};
        if (!rx_act[sel_r] || !awake) begin
            bcnt_nxt = 3'h0;
        end else if (bit_stb[sel_r]) begin
            sh_nxt = byte_data;
            bcnt_nxt = bcnt_r + 3'h1;
            byte_done = bcnt_r == 3'h7;
        end
        // a full buffer cannot stall the cable, so the byte is flagged lost
        ovr_nxt = byte_done & ~buf_ready;
        for (int p = 0; p < NP; p++) begin
            fo_nxt[p] = 1'b0;
            so_nxt[p] = 1'b0;
            foe_nxt[p] = 1'b0;
            soe_nxt[p] = 1'b0;
            // detectors kept in sleep on every port except one disabled with its interrupt enable clear
            det_nxt[p] = awake | ~(port_disabled_in[p] & ~port_int_en_in[p]);
            rxe_nxt[p] = awake | det_nxt[p];
            if (rx_act[p]) begin
                rxe_nxt[p] = 1'b1;
            end else if (awake && rx_act[sel_r] && conn[p] && !port_disabled_in[p] && !port_suspended_in[p]) begin
                // repeat strobe on first pair, data on second
                foe_nxt[p] = 1'b1;
                soe_nxt[p] = 1'b1;
                fo_nxt[p] = strobe_lvl[sel_r];
                so_nxt[p] = data_lvl[sel_r];
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_r <= '0;
            bcnt_r <= 3'h0;
            sh_r <= 8'h00;
            spd_r <= 2'h0;
            ovr_r <= 1'b0;
            fo_r <= '0;
            foe_r <= '0;
            so_r <= '0;
            soe_r <= '0;
            rxe_r <= '1;
            det_r <= '1;
        end else begin
            sel_r <= sel_nxt;
            bcnt_r <= bcnt_nxt;
            sh_r <= sh_nxt;
            spd_r <= spd_nxt;
            ovr_r <= ovr_nxt;
            fo_r <= fo_nxt;
            foe_r <= foe_nxt;
            so_r <= so_nxt;
            soe_r <= soe_nxt;
            rxe_r <= rxe_nxt;
            det_r <= det_nxt;
        end
    end

    // bytes handed over on the shared system clock
    pplp_buf2 #(
        .W(8),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .in_valid_in(byte_done),
        .in_data_in(byte_data),
        .in_ready_out(buf_ready),
        .out_valid_out(llc_rx_valid_out),
        .out_data_out(llc_rx_data_out),
        .out_ready_in(llc_rx_ready_in)
    );

    // ************************************************
    // outputs
    // ************************************************
    logic gate_r, gate_nxt, gen_r, gen_nxt, lp_r, lp_nxt, deep_r, deep_nxt;

    always_comb begin
        gen_nxt = st_nxt == st_active || st_nxt == st_wake;
        lp_nxt = !gen_nxt;
        deep_nxt = st_nxt == st_deep;
        // gate opens only once the wake count has run out
        gate_nxt = st_nxt == st_active;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gen_r <= 1'b1;
            gate_r <= 1'b1;
            lp_r <= 1'b0;
            deep_r <= 1'b0;
        end else begin
            gen_r <= gen_nxt;
            gate_r <= gate_nxt;
            lp_r <= lp_nxt;
            deep_r <= deep_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign reg_ack_out = ack_r;
    assign phy_ack_out = phy_ack_r;
    assign phy_access_fail_out = phy_fail_r;
    assign cable_pair_first_out = fo_r;
    assign cable_pair_first_oe_out = foe_r;
    assign cable_pair_second_out = so_r;
    assign cable_pair_second_oe_out = soe_r;
    assign rx_en_out = rxe_r;
    assign detect_en_out = det_r;
    assign arb_status_out = cmp;
    assign next_speed_out = spd_r;
    assign port_connected_out = conn_prev_r;
    assign rx_overrun_out = ovr_r;
    // generators stopped in both sleep states
    assign clk_gen_en_out = gen_r;
    assign sysclk_gate_en_out = gate_r;
    assign low_power_out = lp_r;
    assign deep_sleep_out = deep_r;
endmodule

//--- hw/pplp_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef PPLP_DEFINES_SVH
`define PPLP_DEFINES_SVH

`define PPLP_HCC_SET_OFS 12'h050
`define PPLP_HCC_CLR_OFS 12'h054
`define PPLP_HCC_LPS_BIT 19
`define PPLP_HCC_RESET 32'h0000_0000

`define PPLP_PWR_D2 2'h2

`define PPLP_CLK_MHZ 10
`define PPLP_CLK_PERIOD_NS 100
`define PPLP_WAKE_MAX_US 2000
`define PPLP_WAKE_CYC (`PPLP_WAKE_MAX_US * `PPLP_CLK_MHZ)
`define PPLP_RX_IDLE_NS 3200
`define PPLP_RX_IDLE_CYC ((`PPLP_RX_IDLE_NS + `PPLP_CLK_PERIOD_NS - 1) / `PPLP_CLK_PERIOD_NS)

`endif

//--- hw/pplp_pkg.sv
// types shared by the port low-power controller
package pplp_pkg;
    typedef enum logic [1:0] {
        st_active,
        st_sleep,
        st_deep,
        st_wake
    } pplp_lp_e;

    typedef logic [1:0] pplp_pwr_t;
    typedef logic [7:0] pplp_byte_t;
endpackage

//--- hw/pplp_port_if.sv
// per-port receive status carried from a port receiver to the controller
`timescale 1ns/1ps
interface pplp_port_if;
    logic rx_active;
    logic bit_stb;
    logic bit_val;
    logic data_lvl;
    logic strobe_lvl;
    logic bias;
    logic [1:0] cmp;
    logic [1:0] speed;

    modport rx (
        output rx_active, bit_stb, bit_val, data_lvl, strobe_lvl, bias, cmp, speed
    );
    modport ctl (
        input rx_active, bit_stb, bit_val, data_lvl, strobe_lvl, bias, cmp, speed
    );
endinterface

//--- hw/pplp_port_rx.sv
// cable port receiver: pin synchroniser and data-strobe decoder
`timescale 1ns/1ps
`include "pplp_defines.svh"
module pplp_port_rx #(
    parameter int IDLE_CYC = `PPLP_RX_IDLE_CYC
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // cable pins
    input wire logic pair_first_in,
    input wire logic pair_second_in,
    input wire logic bias_sense_in,
    input wire logic [1:0] cmp_in,
    input wire logic [1:0] cm_speed_in,
    // status toward the controller
    pplp_port_if.rx port
);
    localparam int SW = 7;
    localparam int CW = $clog2(IDLE_CYC + 1);

    logic [SW-1:0] s1_r, s2_r, s3_r, st_r;
    logic [SW-1:0] s1_nxt, s2_nxt, s3_nxt, st_nxt;
    logic par_r, stb_r, val_r;
    logic par_nxt, stb_nxt, val_nxt;
    logic [CW-1:0] idle_r, idle_nxt;

    // ************************************************
    // synchroniser
    // ************************************************
    always_comb begin
        s1_nxt = {cm_speed_in, cmp_in, bias_sense_in, pair_second_in, pair_first_in};
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        // a bit changes only once the last two stages agree
        st_nxt = (s2_r & s3_r) | (st_r & (s2_r | s3_r));
    end

    // ************************************************
    // data-strobe decode
    // ************************************************
    always_comb begin
        par_nxt = st_r[0] ^ st_r[1];
        stb_nxt = par_nxt != par_r;
        val_nxt = stb_nxt ? st_r[0] : val_r;
        if (stb_nxt) begin
            idle_nxt = CW'(IDLE_CYC);
        end else if (idle_r != '0) begin
            idle_nxt = idle_r - 1'b1;
        end else begin
            idle_nxt = idle_r;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            st_r <= '0;
            par_r <= 1'b0;
            stb_r <= 1'b0;
            val_r <= 1'b0;
            idle_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            st_r <= st_nxt;
            par_r <= par_nxt;
            stb_r <= stb_nxt;
            val_r <= val_nxt;
            idle_r <= idle_nxt;
        end
    end

    assign port.rx_active = idle_r != '0;
    assign port.bit_stb = stb_r;
    assign port.bit_val = val_r;
    assign port.data_lvl = st_r[0];
    assign port.strobe_lvl = st_r[1];
    assign port.bias = st_r[2];
    assign port.cmp = st_r[4:3];
    assign port.speed = st_r[6:5];
endmodule

//--- hw/pplp_buf2.sv
// small shift-register buffer with valid and ready on both sides
`timescale 1ns/1ps
module pplp_buf2 #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // filling side
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    // draining side
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in
);
    logic [DEPTH-1:0][W-1:0] mem_r, mem_nxt, sh_mem;
    logic [DEPTH-1:0] vld_r, vld_nxt, sh_vld, wr_mask;
    logic push, pop;

    always_comb begin
        pop = vld_r[0] & out_ready_in;
        push = in_valid_in & ~vld_r[DEPTH-1];
        // head always sits in entry 0 so the output is a plain register
        sh_mem = pop ? {W'(0), mem_r[DEPTH-1:1]} : mem_r;
        sh_vld = pop ? {1'b0, vld_r[DEPTH-1:1]} : vld_r;
        wr_mask = ~sh_vld & {sh_vld[DEPTH-2:0], 1'b1};
        mem_nxt = sh_mem;
        vld_nxt = sh_vld;
        for (int i = 0; i < DEPTH; i++) begin
            if (push && wr_mask[i]) begin
                mem_nxt[i] = in_data_in;
                vld_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_r <= '0;
            vld_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            vld_r <= vld_nxt;
        end
    end

    assign in_ready_out = ~vld_r[DEPTH-1];
    assign out_valid_out = vld_r[0];
    assign out_data_out = mem_r[0];
endmodule

//--- testbench/pplp_ctrl_assertions.sv
// concurrent checks on the port low-power controller ports
`timescale 1ns/1ps
module pplp_ctrl_assertions #(
    parameter int WAKE_CYC = 20
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // register and phy access
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_ack_out,
    input wire logic phy_req_in,
    input wire logic phy_ack_out,
    input wire logic phy_access_fail_out,
    // power
    input wire logic [1:0] host_pwr_state_in,
    input wire logic clk_gen_en_out,
    input wire logic sysclk_gate_en_out,
    input wire logic low_power_out,
    input wire logic deep_sleep_out,
    // link stream
    input wire logic [7:0] llc_rx_data_out,
    input wire logic llc_rx_valid_out,
    input wire logic llc_rx_ready_in
);
    // ****
    // checks
    // ****
    localparam int WM1 = WAKE_CYC - 1;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_reg_ack: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out)
        else $error("no register ack");
    a_phy_answer: assert property (phy_req_in |=> (phy_ack_out ^ phy_access_fail_out))
        else $error("phy answer wrong");
    a_phy_refuse: assert property (phy_req_in && low_power_out |=> phy_access_fail_out)
        else $error("phy not refused");
    a_gate_delay: assert property ($rose(clk_gen_en_out) |->
        ##WM1 !sysclk_gate_en_out ##1 sysclk_gate_en_out)
        else $error("link clock release late");
    a_gate_low: assert property (low_power_out |-> !sysclk_gate_en_out)
        else $error("link clock running in low power");
    a_entry_host: assert property ($fell(clk_gen_en_out) |-> $past(host_pwr_state_in) >= 2'h2)
        else $error("low power entered in wrong host state");
    a_lps_wake: assert property (reg_wr_in && reg_addr_in == 12'h050 && reg_wdata_in[19]
        && low_power_out |-> ##[1:2] clk_gen_en_out)
        else $error("no wake on write");
    a_deep_rise: assert property ($rose(deep_sleep_out) |-> ##[0:1] low_power_out)
        else $error("deep sleep without low power");
    a_stream_hold: assert property (llc_rx_valid_out && !llc_rx_ready_in |=>
        llc_rx_valid_out && $stable(llc_rx_data_out))
        else $error("stalled word changed");

    c_deep: cover property ($rose(deep_sleep_out));
    c_gate: cover property ($rose(sysclk_gate_en_out));
    c_fail: cover property (phy_access_fail_out);
endmodule

bind pplp_ctrl pplp_ctrl_assertions #(.WAKE_CYC(WAKE_CYC)) u_pplp_ctrl_assertions (.*);

//--- testbench/pplp_cable_node.sv
// remote cable node: bias source and data-strobe sender
`timescale 1ns/1ps
module pplp_cable_node (
    // cable lines toward the port
    output logic data_out,
    output logic strobe_out,
    output logic bias_out
);
    // ****
    // node behaviour
    // ****
    initial begin
        data_out = 1'b0;
        strobe_out = 1'b0;
        bias_out = 1'b0;
    end
    task automatic set_bias(input logic b);
        bias_out = b;
    endtask
    // one line moves per bit, msb first
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #400;
            if (b[i] == data_out)
                strobe_out = ~strobe_out;
            else
                data_out = b[i];
            #400;
        end
    endtask
endmodule

//--- testbench/pplp_ctrl_tb_top.sv
// self-checking bench for the port low-power controller
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fails++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module pplp_ctrl_tb_top;
    typedef struct packed {
        logic [11:0] wa;
        logic [31:0] wd;
        logic [11:0] ra;
        logic [31:0] ex;
    } pplp_row_s;
    logic ref_clk_in, rst_in, reg_wr_in, reg_rd_in, phy_req_in, llc_rx_ready_in;
    logic reg_ack_out, phy_ack_out, phy_access_fail_out, llc_rx_valid_out, rx_overrun_out;
    logic clk_gen_en_out, sysclk_gate_en_out, low_power_out, deep_sleep_out;
    logic [11:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, q;
    logic [1:0] host_pwr_state_in, port_disabled_in, port_suspended_in, port_int_en_in, next_speed_out;
    logic [1:0] cable_pair_first_in, cable_pair_second_in, bias_sense_in, rx_en_out, detect_en_out;
    logic [1:0] cable_pair_first_out, cable_pair_first_oe_out, cable_pair_second_out;
    logic [1:0] cable_pair_second_oe_out, port_connected_out;
    logic [1:0][1:0] cmp_in, cm_speed_in, arb_status_out;
    logic [7:0] llc_rx_data_out;
    logic [7:0] got[$];
    int fails, check_count, cyc, ovr, k, n;
    pplp_row_s rows [5] = '{
        '{12'h050, 32'h0008_0000, 12'h054, 32'h0008_0000},
        '{12'h054, 32'h0008_0000, 12'h050, 32'h0000_0000},
        '{12'h050, 32'h8000_0001, 12'h050, 32'h8000_0001},
        '{12'h054, 32'hFFFF_FFFF, 12'h054, 32'h0000_0000},
        '{12'h0A0, 32'h1234_5678, 12'h0A0, 32'h0000_0000}};

    pplp_ctrl #(.WAKE_CYC(20)) u_pplp_ctrl (.*);
    pplp_cable_node u_pplp_cable_node[1:0] (
        .data_out(cable_pair_first_in),
        .strobe_out(cable_pair_second_in),
        .bias_out(bias_sense_in)
    );

    // ****
    // clock, timeout and helpers
    // ****
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cyc++;
        if (rx_overrun_out === 1'b1)
            ovr++;
        if (cyc == 8000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        reg_wr_in = w;
        reg_rd_in = !w;
        reg_addr_in = a;
        reg_wdata_in = d;
        tick(1);
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        q = reg_rdata_out;
        `CHK("ack", 1'b1, reg_ack_out)
        tick(1);
    endtask
    task automatic phy(input logic ok);
        phy_req_in = 1'b1;
        tick(1);
        phy_req_in = 1'b0;
        `CHK("phy_ack", ok, phy_ack_out)
        `CHK("phy_fail", !ok, phy_access_fail_out)
    endtask
    task automatic wait_lp(input logic lp);
        for (k = 0; k < 30 && low_power_out !== lp; k++)
            tick(1);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        {rst_in, reg_wr_in, reg_rd_in, phy_req_in, llc_rx_ready_in} = 5'h10;
        {reg_addr_in, reg_wdata_in, host_pwr_state_in} = '0;
        {port_disabled_in, port_suspended_in, port_int_en_in, cmp_in, cm_speed_in} = '0;
        tick(10);
        rst_in = 1'b0;
        `CHK("reset", 3'b110, {clk_gen_en_out, sysclk_gate_en_out, low_power_out})
        foreach (rows[i]) begin
            acc(1'b1, rows[i].wa, rows[i].wd);
            acc(1'b0, rows[i].ra, 32'h0);
            `CHK("reg", rows[i].ex, q)
        end
        $display("rows done");
        host_pwr_state_in = 2'h1;
        tick(10);
        `CHK("no_entry_d1", 1'b0, low_power_out)
        {host_pwr_state_in, port_disabled_in} = 4'hE;
        wait_lp(1'b1);
        `CHK("deep", 3'b100, {deep_sleep_out, sysclk_gate_en_out, clk_gen_en_out})
        phy(1'b0);
        `CHK("detect", 2'h1, detect_en_out)
        {port_disabled_in, port_int_en_in} = 4'h3;
        u_pplp_cable_node[1].set_bias(1'b1);
        wait_lp(1'b0);
        `CHK("conn_wake", 1'b1, clk_gen_en_out)
        phy(1'b0);
        for (n = 1; sysclk_gate_en_out !== 1'b1 && n < 100; n++)
            tick(1);
        `CHK("wake_cyc", 20, n)
        phy(1'b1);
        $display("sleep done");
        port_suspended_in = 2'h2;
        wait_lp(1'b1);
        `CHK("light", 1'b0, deep_sleep_out)
        acc(1'b1, 12'h050, 32'h0008_0000);
        wait_lp(1'b0);
        tick(40);
        `CHK("lps_hold", 2'b11, {clk_gen_en_out, sysclk_gate_en_out})
        acc(1'b1, 12'h054, 32'h0008_0000);
        wait_lp(1'b1);
        `CHK("reenter", 1'b1, low_power_out)
        u_pplp_cable_node[1].set_bias(1'b0);
        wait_lp(1'b0);
        `CHK("disc_wake", 1'b1, clk_gen_en_out)
        {host_pwr_state_in, port_suspended_in} = '0;
        tick(25);
        $display("suspend done");
        cmp_in = {2'h3, 2'h1};
        cm_speed_in = {2'h1, 2'h2};
        u_pplp_cable_node[0].set_bias(1'b1);
        u_pplp_cable_node[1].set_bias(1'b1);
        tick(10);
        `CHK("arb", 4'hD, arb_status_out)
        `CHK("speed", 2'h2, next_speed_out)
        u_pplp_cable_node[0].send(8'hA5);
        `CHK("oe", 7'b1110101, {port_connected_out, cable_pair_first_oe_out, cable_pair_second_oe_out, rx_en_out[0]})
        u_pplp_cable_node[0].send(8'h3C);
        u_pplp_cable_node[0].send(8'hF0);
        tick(40);
        `CHK("overrun", 1, ovr)
        llc_rx_ready_in = 1'b1;
        for (k = 0; k < 10; k++) begin
            if (llc_rx_valid_out === 1'b1)
                got.push_back(llc_rx_data_out);
            tick(1);
        end
        `CHK("bytes", 2, got.size())
        `CHK("byte0", 8'hA5, got[0])
        `CHK("byte1", 8'h3C, got[1])
        $display("receive done");
        wrap_up();
    end
endmodule
